// ---- pkg/audio_io_pkg.sv ----
// constants and carrier types for the audio routing matrix
//
// Overview of operation
// R01 - one of three sources feeds the grid
// R02 - analog left from front or rear jack
// R03 - primary input: left, sum or stereo
// R04 - reset: analog, front jack, left only
// R05 - return input: left, sum or stereo
// R06 - main out: stereo, sum or copy
// R07 - main output gain zero to eighteen dB
// R08 - same main gain on digital and usb
// R09 - main invert negates both channels together
// R10 - second out: left, sum or stereo
// R11 - second output own gain and invert
// R12 - mirror feeds second from main copy
// R13 - only one digital port standard enabled
// R14 - both digital outs share one feed
// R15 - host stops usb streaming before resize
// R16 - settings global, applied immediately
// R17 - mono sums halved, never wrap
// R18 - left-only places left on both channels
`default_nettype none
package audio_io_pkg;
   localparam int SAMPLE_W = 24;
   localparam int GAIN_W = 5;
   localparam logic [GAIN_W-1:0] GAIN_MAX_DB = 5'h12;
   localparam int ACC_W = SAMPLE_W + 4;
   localparam int USB_DEPTH_W = 4;
   localparam logic [USB_DEPTH_W-1:0] USB_DEPTH_RST = 4'h4;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } stereo_t;

   typedef enum logic [1:0] {
      SRC_ANALOG,
      SRC_USB,
      SRC_DIGITAL
   } grid_src_t;

   typedef enum logic [1:0] {
      IN_LEFT_ONLY,
      IN_SUM,
      IN_STEREO
   } in_mode_t;

   typedef enum logic [1:0] {
      MAIN_STEREO,
      MAIN_SUM,
      MAIN_COPY_L
   } main_mode_t;

   typedef enum logic [1:0] {
      DFEED_MAIN,
      DFEED_SECOND,
      DFEED_INPUT
   } dig_feed_t;

   typedef enum logic {
      PORT_SPDIF,
      PORT_AES
   } dig_port_t;

   typedef enum logic {
      JACK_FRONT,
      JACK_REAR
   } jack_t;

   typedef struct packed {
      grid_src_t grid_src;
      jack_t left_jack;
      in_mode_t primary_mode;
      in_mode_t return_mode;
      main_mode_t main_mode;
      logic [GAIN_W-1:0] main_gain_db;
      logic main_invert;
      in_mode_t second_mode;
      logic [GAIN_W-1:0] second_gain_db;
      logic second_invert;
      logic mirror_main_to_second;
      dig_port_t dig_port;
      dig_feed_t dig_feed;
      logic [USB_DEPTH_W-1:0] usb_depth;
   } io_cfg_t;

   localparam io_cfg_t CFG_RST = '{
      grid_src: SRC_ANALOG,
      left_jack: JACK_FRONT,
      primary_mode: IN_LEFT_ONLY,
      return_mode: IN_LEFT_ONLY,
      main_mode: MAIN_STEREO,
      main_gain_db: '0,
      main_invert: 1'b0,
      second_mode: IN_STEREO,
      second_gain_db: '0,
      second_invert: 1'b0,
      mirror_main_to_second: 1'b0,
      dig_port: PORT_SPDIF,
      dig_feed: DFEED_MAIN,
      usb_depth: USB_DEPTH_RST
   };
endpackage
`default_nettype wire

// ---- src/audio_io_routing_matrix.sv ----
// routing, channel format, gain and polarity for the audio io matrix
`default_nettype none
module audio_io_routing_matrix
   import audio_io_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire io_cfg_t cfg_in,
   input wire logic cfg_load_in,
   input wire logic sample_valid_in,
   input wire logic signed [SAMPLE_W-1:0] front_instrument_jack_in,
   input wire stereo_t rear_in,
   input wire stereo_t return_in,
   input wire stereo_t usb_in,
   input wire stereo_t digital_in,
   input wire stereo_t grid_out_in,
   input wire stereo_t loop_block_in,
   output var stereo_t grid_feed_out,
   output var stereo_t return_feed_out,
   output var stereo_t main_dac_out,
   output var stereo_t second_dac_out,
   output var stereo_t usb_out,
   output var stereo_t digital_out,
   output var logic spdif_en_out,
   output var logic aes_en_out,
   output var logic [USB_DEPTH_W-1:0] usb_depth_out,
   output var logic sample_valid_out
);

   // ***************************************************
   // live configuration
   // ***************************************************
   io_cfg_t cfg_r, cfg_nxt;
   logic spdif_en_r, spdif_en_nxt, aes_en_r, aes_en_nxt;

   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_load_in) begin
         cfg_nxt = cfg_in; // [R16]
         // clamp gains to the documented range
         if (cfg_in.main_gain_db > GAIN_MAX_DB) begin
            cfg_nxt.main_gain_db = GAIN_MAX_DB;
         end
         if (cfg_in.second_gain_db > GAIN_MAX_DB) begin
            cfg_nxt.second_gain_db = GAIN_MAX_DB;
         end
      end
      // enables kept in flops so the pins come straight off a register
      spdif_en_nxt = (cfg_nxt.dig_port == PORT_SPDIF); // [R13]
      aes_en_nxt = (cfg_nxt.dig_port == PORT_AES); // [R13]
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cfg_r <= CFG_RST; // [R04]
         spdif_en_r <= (CFG_RST.dig_port == PORT_SPDIF); // [R04]
         aes_en_r <= (CFG_RST.dig_port == PORT_AES);
      end else if (ce_in) begin
         cfg_r <= cfg_nxt;
         spdif_en_r <= spdif_en_nxt;
         aes_en_r <= aes_en_nxt;
      end
   end

   // ***************************************************
   // helpers
   // ***************************************************
   // halving the sum keeps full-scale inputs from wrapping
   function automatic logic signed [SAMPLE_W-1:0] half_sum(
      input logic signed [SAMPLE_W-1:0] a,
      input logic signed [SAMPLE_W-1:0] b);
      logic signed [SAMPLE_W:0] s;
      s = '0;
      s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
      return s[SAMPLE_W:1]; // [R17]
   endfunction

   function automatic stereo_t fmt_in(input stereo_t x, input in_mode_t m);
      stereo_t y;
      y = x;
      case (m)
         IN_LEFT_ONLY: begin
            y.right = x.left; // [R18]
         end
         IN_SUM: begin
            y.left = half_sum(x.left, x.right);
            y.right = y.left;
         end
         IN_STEREO: begin
            y = x;
         end
         default: begin
            y = x;
         end
      endcase
      return y;
   endfunction

   // negation saturates so the most negative code cannot wrap
   function automatic logic signed [SAMPLE_W-1:0] neg_sat(
      input logic signed [SAMPLE_W-1:0] a);
      logic signed [SAMPLE_W-1:0] r;
      r = -a;
      if (a == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
         r = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end
      return r;
   endfunction

   // gain in whole dB via a 1/16 linear table, then saturate
   function automatic logic signed [SAMPLE_W-1:0] gain_ch(
      input logic signed [SAMPLE_W-1:0] a,
      input logic [GAIN_W-1:0] db,
      input logic inv);
      logic [8:0] k;
      logic signed [SAMPLE_W+9:0] p;
      logic signed [SAMPLE_W+5:0] q;
      logic signed [SAMPLE_W-1:0] r;
      k = 9'h010;
      p = '0;
      q = '0;
      r = '0;
      case (db)
         5'h00: k = 9'h010;
         5'h01: k = 9'h012;
         5'h02: k = 9'h014;
         5'h03: k = 9'h017;
         5'h04: k = 9'h019;
         5'h05: k = 9'h01c;
         5'h06: k = 9'h020;
         5'h07: k = 9'h024;
         5'h08: k = 9'h028;
         5'h09: k = 9'h02d;
         5'h0a: k = 9'h033;
         5'h0b: k = 9'h039;
         5'h0c: k = 9'h040;
         5'h0d: k = 9'h047;
         5'h0e: k = 9'h050;
         5'h0f: k = 9'h05a;
         5'h10: k = 9'h065;
         5'h11: k = 9'h071;
         5'h12: k = 9'h07f;
         default: k = 9'h07f;
      endcase
      p = a * $signed({1'b0, k});
      q = p[SAMPLE_W+9:4];
      if (q > $signed({{7{1'b0}}, {(SAMPLE_W-1){1'b1}}})) begin
         r = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (q < $signed({{7{1'b1}}, {(SAMPLE_W-1){1'b0}}})) begin
         r = {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
         r = q[SAMPLE_W-1:0];
      end
      if (inv) begin
         r = neg_sat(r);
      end
      return r;
   endfunction

   // ***************************************************
   // sample path
   // ***************************************************
   stereo_t analog_pair, grid_sel, main_fmt, main_g, sec_src, sec_g, dig_sel;
   stereo_t grid_r, grid_nxt, ret_r, ret_nxt, main_r, main_nxt;
   stereo_t sec_r, sec_nxt, dig_r, dig_nxt;
   logic valid_r, valid_nxt;

   always_comb begin
      analog_pair = rear_in;
      if (cfg_r.left_jack == JACK_FRONT) begin
         analog_pair.left = front_instrument_jack_in; // [R02]
      end
      case (cfg_r.grid_src) // [R01]
         SRC_ANALOG: grid_sel = fmt_in(analog_pair, cfg_r.primary_mode);
         SRC_USB: grid_sel = usb_in;
         SRC_DIGITAL: grid_sel = digital_in;
         default: grid_sel = analog_pair;
      endcase
      if (cfg_r.grid_src != SRC_ANALOG) begin
         grid_sel = fmt_in(grid_sel, cfg_r.primary_mode); // [R03]
      end
      main_fmt = grid_out_in;
      case (cfg_r.main_mode) // [R06]
         MAIN_STEREO: main_fmt = grid_out_in;
         MAIN_SUM: begin
            main_fmt.left = half_sum(grid_out_in.left, grid_out_in.right);
            main_fmt.right = main_fmt.left;
         end
         MAIN_COPY_L: main_fmt.right = grid_out_in.left;
         default: main_fmt = grid_out_in;
      endcase
      main_g.left = gain_ch(main_fmt.left, cfg_r.main_gain_db,
                            cfg_r.main_invert); // [R07] [R09]
      main_g.right = gain_ch(main_fmt.right, cfg_r.main_gain_db,
                             cfg_r.main_invert); // [R09]
      // mirror takes the main copy before main gain and polarity
      sec_src = cfg_r.mirror_main_to_second ? main_fmt
                                            : loop_block_in; // [R12]
      sec_src = fmt_in(sec_src, cfg_r.second_mode); // [R10]
      sec_g.left = gain_ch(sec_src.left, cfg_r.second_gain_db,
                           cfg_r.second_invert); // [R11]
      sec_g.right = gain_ch(sec_src.right, cfg_r.second_gain_db,
                            cfg_r.second_invert); // [R11]
      case (cfg_r.dig_feed) // [R14]
         DFEED_MAIN: dig_sel = main_g; // [R08]
         DFEED_SECOND: dig_sel = sec_g;
         DFEED_INPUT: dig_sel = grid_sel;
         default: dig_sel = main_g;
      endcase
      grid_nxt = grid_r;
      ret_nxt = ret_r;
      main_nxt = main_r;
      sec_nxt = sec_r;
      dig_nxt = dig_r;
      valid_nxt = sample_valid_in;
      if (sample_valid_in) begin
         grid_nxt = grid_sel;
         ret_nxt = fmt_in(return_in, cfg_r.return_mode); // [R05]
         main_nxt = main_g;
         sec_nxt = sec_g;
         dig_nxt = dig_sel;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         grid_r <= '0;
         ret_r <= '0;
         main_r <= '0;
         sec_r <= '0;
         dig_r <= '0;
         valid_r <= 1'b0;
      end else if (ce_in) begin
         grid_r <= grid_nxt;
         ret_r <= ret_nxt;
         main_r <= main_nxt;
         sec_r <= sec_nxt;
         dig_r <= dig_nxt;
         valid_r <= valid_nxt;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   always_comb begin
      grid_feed_out = grid_r;
      return_feed_out = ret_r;
      main_dac_out = main_r;
      usb_out = main_r; // [R08]
      second_dac_out = sec_r;
      digital_out = dig_r;
      spdif_en_out = spdif_en_r; // [R13]
      aes_en_out = aes_en_r; // [R13]
      // resize only takes effect safely with streaming stopped
      usb_depth_out = cfg_r.usb_depth; // [R15]
      sample_valid_out = valid_r;
   end

endmodule
`default_nettype wire

// ---- bench/audio_io_routing_matrix_props.sv ----
// assertion checker for the audio routing matrix
`default_nettype none
module audio_io_routing_matrix_props
   import audio_io_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire io_cfg_t cfg_in,
   input wire logic cfg_load_in,
   input wire logic sample_valid_in,
   input wire stereo_t main_dac_out,
   input wire stereo_t second_dac_out,
   input wire stereo_t usb_out,
   input wire logic spdif_en_out,
   input wire logic aes_en_out,
   input wire logic [USB_DEPTH_W-1:0] usb_depth_out,
   input wire logic sample_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   sequence s_load;
      ce_in && cfg_load_in && !srst_in;
   endsequence
   sequence s_take;
      ce_in && sample_valid_in && !srst_in;
   endsequence
   property p_valid_lat;
      disable iff (srst_in) s_take |=> sample_valid_out;
   endproperty
   a_valid_lat: assert property (p_valid_lat)
      else $error("no valid out");
   property p_valid_pulse;
      disable iff (srst_in) ce_in && !sample_valid_in |=> !sample_valid_out;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse)
      else $error("extra valid");
   property p_onehot;
      disable iff (srst_in) spdif_en_out != aes_en_out;
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("both ports");
   property p_port_sel;
      disable iff (srst_in)
         s_load |=> aes_en_out == ($past(cfg_in.dig_port) == PORT_AES);
   endproperty
   a_port_sel: assert property (p_port_sel)
      else $error("port sel");
   property p_depth;
      disable iff (srst_in)
         s_load |=> usb_depth_out == $past(cfg_in.usb_depth);
   endproperty
   a_depth: assert property (p_depth)
      else $error("depth");
   property p_usb_eq;
      disable iff (srst_in) usb_out == main_dac_out;
   endproperty
   a_usb_eq: assert property (p_usb_eq)
      else $error("usb differs");
   property p_hold;
      disable iff (srst_in) ce_in && !sample_valid_in
         |=> $stable(main_dac_out) && $stable(second_dac_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output moved");
   // reset itself is the cause here, so no disable
   property p_reset;
      srst_in && ce_in |=> spdif_en_out && !sample_valid_out
         && usb_depth_out == USB_DEPTH_RST;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset state");
endmodule
bind audio_io_routing_matrix audio_io_routing_matrix_props i_props (
   .clk_sys_in, .srst_in, .ce_in, .cfg_in, .cfg_load_in, .sample_valid_in,
   .main_dac_out, .second_dac_out, .usb_out, .spdif_en_out, .aes_en_out,
   .usb_depth_out, .sample_valid_out);
`default_nettype wire

// ---- bench/dig_sink_model.sv ----
// digital receiver model latching the shared digital output feed
`default_nettype none
module dig_sink_model
   import audio_io_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic valid_in,
   input wire stereo_t dig_in,
   output var stereo_t dig_cap_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial dig_cap_out = '0;
   // latches only on a strobe, between strobes the line is meaningless
   always @(posedge clk_sys_in) begin
      if (valid_in) begin
         dig_cap_out <= dig_in;
      end
   end
endmodule
`default_nettype wire

// ---- bench/test_audio_io_routing_matrix.sv ----
// self-checking bench for the audio routing matrix
`default_nettype none
module test_audio_io_routing_matrix
   import audio_io_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1;
   logic cfg_load_in = 1'b0, sample_valid_in = 1'b0;
   logic signed [SAMPLE_W-1:0] front_s = 24'h000064;
   io_cfg_t cfg_in = CFG_RST, c;
   stereo_t rear_s, ret_s, usb_s, dig_s, gout_s, loop_s, cap_o;
   stereo_t grid_o, ret_o, main_o, sec_o, usb_o, dig_o;
   stereo_t rt[3], mt[3], st2[3], dt[3], gm[3], gs[3];
   logic [GAIN_W-1:0] gdb[3];
   logic spdif_o, aes_o, vout_o;
   logic [USB_DEPTH_W-1:0] depth_o;
   int err_total = 0, cmp_count = 0;
   audio_io_routing_matrix i_audio_io_routing_matrix (
      .clk_sys_in, .srst_in, .ce_in, .cfg_in, .cfg_load_in, .sample_valid_in,
      .front_instrument_jack_in(front_s), .rear_in(rear_s), .return_in(ret_s),
      .usb_in(usb_s), .digital_in(dig_s), .grid_out_in(gout_s),
      .loop_block_in(loop_s), .grid_feed_out(grid_o), .return_feed_out(ret_o),
      .main_dac_out(main_o), .second_dac_out(sec_o), .usb_out(usb_o),
      .digital_out(dig_o), .spdif_en_out(spdif_o), .aes_en_out(aes_o),
      .usb_depth_out(depth_o), .sample_valid_out(vout_o));
   dig_sink_model i_dig_sink_model (.clk_sys_in, .valid_in(vout_o),
      .dig_in(dig_o), .dig_cap_out(cap_o));
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   function automatic stereo_t st(input int l, input int r);
      return '{left: SAMPLE_W'(l), right: SAMPLE_W'(r)};
   endfunction
   task automatic chk(input string n, input logic [47:0] s, logic [47:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // load, one sample, then one more edge so the sink has latched
   task automatic run(input io_cfg_t k);
      @(posedge clk_sys_in);
      cfg_in <= k;
      cfg_load_in <= 1'b1;
      @(posedge clk_sys_in);
      cfg_load_in <= 1'b0;
      sample_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      sample_valid_in <= 1'b0;
      #1;
      for (int i = 0; i < 4 && vout_o !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      chk("valid", vout_o, 1'b1);
      @(posedge clk_sys_in);
      #1;
   endtask
   initial begin
      #20us;
      err_total++;
      conclude();
   end
   initial begin
      rear_s = st(7, 9);
      ret_s = st(40, 60);
      usb_s = st(10, 20);
      dig_s = st(21, 23);
      gout_s = st(100, 300);
      loop_s = st(5, 7);
      rt = '{st(40, 40), st(50, 50), st(40, 60)};
      mt = '{st(100, 300), st(200, 200), st(100, 100)};
      st2 = '{st(5, 5), st(6, 6), st(5, 7)};
      dt = '{mt[0], st2[1], st(21, 23)};
      gdb = '{5'h06, 5'h12, 5'h1f};
      gm = '{st(200, 600), st(793, 2381), st(793, 2381)};
      gs = '{st(10, 14), st(39, 55), st(39, 55)};
      repeat (3) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      chk("spdif", spdif_o, 1'b1);
      chk("depth", depth_o, USB_DEPTH_RST);
      c = CFG_RST;
      run(c);
      chk("grid", grid_o, st(100, 100));
      c.primary_mode = IN_STEREO;
      c.left_jack = JACK_REAR;
      run(c);
      chk("grid", grid_o, st(7, 9));
      c.left_jack = JACK_FRONT;
      run(c);
      chk("grid", grid_o, st(100, 9));
      c.grid_src = SRC_USB;
      run(c);
      chk("grid", grid_o, st(10, 20));
      c.primary_mode = IN_SUM;
      run(c);
      chk("grid", grid_o, st(15, 15));
      @(posedge clk_sys_in);
      usb_s <= st(8388607, 8388607);
      run(c);
      chk("grid", grid_o, st(8388607, 8388607));
      c.grid_src = SRC_DIGITAL;
      c.primary_mode = IN_STEREO;
      for (int m = 0; m < 3; m++) begin
         c.return_mode = in_mode_t'(m);
         c.main_mode = main_mode_t'(m);
         c.second_mode = in_mode_t'(m);
         c.dig_feed = dig_feed_t'(m);
         c.dig_port = dig_port_t'(m == 1);
         run(c);
         chk("return", ret_o, rt[m]);
         chk("main", main_o, mt[m]);
         chk("usb", usb_o, mt[m]);
         chk("second", sec_o, st2[m]);
         chk("dig", cap_o, dt[m]);
         chk("aes", aes_o, m == 1);
      end
      c.main_mode = MAIN_STEREO;
      c.dig_feed = DFEED_MAIN;
      for (int g = 0; g < 3; g++) begin
         c.main_gain_db = gdb[g];
         c.second_gain_db = gdb[g];
         run(c);
         chk("main", main_o, gm[g]);
         chk("dig", cap_o, gm[g]);
         chk("second", sec_o, gs[g]);
      end
      c.main_gain_db = 5'h06;
      c.second_gain_db = 5'h06;
      c.main_invert = 1'b1;
      c.second_invert = 1'b1;
      run(c);
      chk("main", main_o, st(-200, -600));
      chk("second", sec_o, st(-10, -14));
      // no usb stream is running while the depth changes
      c.usb_depth = 4'h9;
      c.mirror_main_to_second = 1'b1;
      c.main_mode = MAIN_SUM;
      c.main_invert = 1'b0;
      c.second_invert = 1'b0;
      c.second_gain_db = 5'h00;
      run(c);
      chk("depth", depth_o, 4'h9);
      chk("main", main_o, st(400, 400));
      chk("second", sec_o, st(200, 200));
      // enable low: a load and a sample must both be ignored
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      cfg_in <= CFG_RST;
      cfg_load_in <= 1'b1;
      sample_valid_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("depth", depth_o, 4'h9);
      chk("main", main_o, st(400, 400));
      chk("valid", vout_o, 1'b0);
      // mid-run reset must bring back the default set
      @(posedge clk_sys_in);
      ce_in <= 1'b1;
      cfg_load_in <= 1'b0;
      sample_valid_in <= 1'b0;
      srst_in <= 1'b1;
      @(posedge clk_sys_in);
      srst_in <= 1'b0;
      #1;
      chk("depth", depth_o, USB_DEPTH_RST);
      chk("spdif", spdif_o, 1'b1);
      chk("main", main_o, st(0, 0));
      conclude();
   end
endmodule
`default_nettype wire
